/* src/apb_bridge_cfg.svh */
// Address map, decode fields and instance constants for the bridge
// What this block does
// - Answer one contiguous 64 MB window as peripheral space.
// - Only a 0.5 MB sub-range holds peripherals; the rest is reserved.
// - Aligned 16 KB blocks, one block per peripheral.
// - A hit asserts that peripheral's single module enable, no other.
// - Drive enable, relative address, attributes, byte enables, write data.
// - On-platform and off-platform ports; each access goes to its owner.
// - System-bus slave port, 32-bit data path for reads and writes.
// - Check protection rules; never forward a forbidden access.
// - Peripherals split over two bridge instances, each reached via one.
// - Integrity checker watches the driven module enables, flags mismatches.
`ifndef APB_BRIDGE_CFG_SVH
`define APB_BRIDGE_CFG_SVH
`define APB_WIN_BASE_HI 6'h00
`define APB_WIN_LSB 26
`define APB_BLK_LSB 14
`define APB_NUM_SLOTS 32
`define APB_SLOT_W 5
`define APB_PLAT_HI_W 7
`define APB_OFS_W 14
`define APB_HALF_SLOTS 16
`define APB_INST_ID 1'h0
`endif

/* src/apb_bridge_pkg.sv */
// Types shared by the bridge modules
package apb_bridge_pkg;
    typedef enum logic [1:0] {
        APB_IDLE = 2'b00,
        APB_ACC = 2'b01,
        APB_ERR1 = 2'b10,
        APB_ERR2 = 2'b11
    } apb_state_type;
endpackage

/* src/apb_integrity_chk.sv */
// Shadow comparator for the module enables driven toward peripherals
`timescale 1ns/10ps
module apb_integrity_chk (
    input wire logic clk,              // System clock
    input wire logic rst,              // Async reset, active high
    input wire logic [31:0] mainVec,   // Signals as driven
    input wire logic [31:0] shadowVec, // Copy of mainVec, inverted on a detected fault
    output logic mismatch_ff           // Sticky mismatch flag
);
    logic nxt_mismatch;

    // Sticky until reset so a single glitch is never missed
    always_comb begin
        nxt_mismatch = mismatch_ff | (mainVec != shadowVec);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mismatch_ff <= 1'b0;
        end else begin
            mismatch_ff <= nxt_mismatch;
        end
    end
endmodule

/* src/apb_bridge.sv */
// System-bus (AHB-Lite) to peripheral register bus bridge
`timescale 1ns/10ps
`include "apb_bridge_cfg.svh"
module apb_bridge
    import apb_bridge_pkg::*;
(
    input wire logic clk,                 // System clock 250 MHz
    input wire logic rst,                 // Async reset, active high
    input wire logic hsel,                // AHB slave select
    input wire logic [31:0] haddr,        // AHB address
    input wire logic [1:0] htrans,        // AHB transfer type
    input wire logic hwrite,              // AHB write
    input wire logic [2:0] hsize,         // AHB size
    input wire logic [3:0] hprot,         // AHB protection attributes
    input wire logic [31:0] hwdata,       // AHB write data
    input wire logic hready,              // AHB bus ready in
    input wire logic [31:0] protAllow,    // Per-slot user access allowed
    input wire logic [31:0] protWrAllow,  // Per-slot write allowed
    input wire logic [31:0] onRdata,      // On-platform read data
    input wire logic onReady,             // On-platform transfer done
    input wire logic [31:0] offRdata,     // Off-platform read data
    input wire logic offReady,            // Off-platform transfer done
    output logic [31:0] hrdata_ff,        // AHB read data
    output logic hreadyout_ff,            // AHB ready out
    output logic hresp_ff,                // AHB error response
    output logic [15:0] onEn_ff,          // On-platform module enables
    output logic [15:0] offEn_ff,         // Off-platform module enables
    output logic [13:0] perAddr_ff,       // Module-relative address
    output logic perWrite_ff,             // Peripheral write
    output logic [3:0] perProt_ff,        // Peripheral attributes
    output logic [3:0] perByteEn_ff,      // Peripheral byte enables
    output logic [31:0] perWdata_ff,      // Peripheral write data
    output logic integrityErr_ff          // Integrity mismatch flag
);
    apb_state_type state_ff, nxt_state;
    logic [31:0] nxt_hrdata;
    logic nxt_hreadyout, nxt_hresp;
    logic [15:0] nxt_onEn, nxt_offEn;
    logic [13:0] nxt_perAddr;
    logic nxt_perWrite;
    logic [3:0] nxt_perProt, nxt_perByteEn;
    logic [31:0] nxt_perWdata;
    logic pendData_ff, nxt_pendData;
    logic [31:0] shadowVec, mainVec;
    logic chkErr;

    // Address phase decode
    logic start, inWindow, inPlat, allowed, isOff;
    logic [`APB_SLOT_W-1:0] slot;
    logic [3:0] be;
    logic [15:0] oneHot;

    // Address map seen from the system bus:
    //   bits 31:26  window select, must match the window base
    //   bits 25:19  sub-range select, zero for the peripheral half-megabyte
    //   bits 18:14  slot, one 16 KB block per peripheral
    //   bits 13:0   offset handed to the peripheral unchanged
    // Slots 0 to 15 sit on the on-platform port, 16 to 31 on the other.
    // 64 MB window match
    assign inWindow = haddr[31:`APB_WIN_LSB] == `APB_WIN_BASE_HI;
    // Platform sub-range only
    // Everything else in the window is reserved and refused
    assign inPlat = haddr[`APB_WIN_LSB-1:`APB_WIN_LSB-`APB_PLAT_HI_W] == '0;
    // 16 KB slot index
    // Offset bits below the slot go to the peripheral unchanged
    assign slot = haddr[`APB_BLK_LSB+`APB_SLOT_W-1:`APB_BLK_LSB];
    // Upper half of slots is off-platform
    assign isOff = slot[`APB_SLOT_W-1];
    // Protection: user needs slot grant, writes need write grant
    // The grants are plain inputs sampled with the address; a system that
    // changes them must do so between transfers, never during one.
    assign allowed = (hprot[1] | protAllow[slot]) &
                     (~hwrite | protWrAllow[slot]);
    assign start = hsel & hready & htrans[1];
    // One-hot enable within the owning port
    assign oneHot = 16'h0001 << slot[`APB_SLOT_W-2:0];

    // Little-endian lanes from size and low address
    // Word size and the unused larger sizes all select every lane
    always_comb begin
        be = 4'hf;
        unique case (hsize)
            3'h0: be = 4'h1 << haddr[1:0];
            3'h1: be = haddr[1] ? 4'hc : 4'h3;
            default: be = 4'hf;
        endcase
    end

    // Main sequencer; a write's data arrives one cycle after its address.
    // A good access: the address is taken at edge 0, enable and offset
    // show just after it, write data is latched at edge 1, and the
    // enable falls at the edge that sees the peripheral ready, together
    // with ready-out rising and the read data loaded.
    // A refused access: error with ready low after edge 0, error with
    // ready high after edge 1, and idle at edge 2, where a new address
    // may already be taken.
    always_comb begin
        nxt_state = state_ff;
        nxt_hrdata = hrdata_ff;
        nxt_hreadyout = hreadyout_ff;
        nxt_hresp = 1'b0;
        nxt_onEn = onEn_ff;
        nxt_offEn = offEn_ff;
        nxt_perAddr = perAddr_ff;
        nxt_perWrite = perWrite_ff;
        nxt_perProt = perProt_ff;
        nxt_perByteEn = perByteEn_ff;
        nxt_perWdata = perWdata_ff;
        nxt_pendData = 1'b0;
        unique case (state_ff)
            APB_IDLE: begin
                nxt_hreadyout = 1'b1;
                if (start) begin
                    // Reserved or denied goes to error, no enable
                    // No enable rises, so no peripheral sees the access
                    if (!(inWindow && inPlat && allowed)) begin
                        nxt_state = APB_ERR1;
                        nxt_hreadyout = 1'b0;
                        nxt_hresp = 1'b1;
                    end else begin
                        nxt_state = APB_ACC;
                        nxt_hreadyout = 1'b0;
                        nxt_pendData = hwrite;
                        nxt_perAddr = haddr[`APB_OFS_W-1:0];
                        nxt_perWrite = hwrite;
                        nxt_perProt = hprot;
                        nxt_perByteEn = be;
                        nxt_onEn = isOff ? 16'h0000 : oneHot;
                        nxt_offEn = isOff ? oneHot : 16'h0000;
                    end
                end
            end
            APB_ACC: begin
                // Wait states: enable and offset hold until port is ready
                // Capture 32-bit write data in its data phase
                if (pendData_ff) begin
                    nxt_perWdata = hwdata;
                end
                if ((|onEn_ff && onReady) || (|offEn_ff && offReady)) begin
                    nxt_hrdata = (|onEn_ff) ? onRdata : offRdata;
                    nxt_onEn = 16'h0000;
                    nxt_offEn = 16'h0000;
                    nxt_hreadyout = 1'b1;
                    nxt_state = APB_IDLE;
                end
            end
            APB_ERR1: begin
                // Two-cycle AHB error: second cycle raises ready
                // Back to idle at once so that an address offered in the
                // second error cycle is still taken
                nxt_hresp = 1'b1;
                nxt_hreadyout = 1'b1;
                nxt_state = APB_IDLE;
            end
            APB_ERR2: begin
                // Never entered; a stray code here falls back to idle
                nxt_hreadyout = 1'b1;
                nxt_state = APB_IDLE;
            end
        endcase
    end

    // State registers; reset leaves ready-out high so the bus never stalls
    // on a bridge that has not yet seen a transfer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= APB_IDLE;
            hrdata_ff <= 32'h0;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
            onEn_ff <= 16'h0;
            offEn_ff <= 16'h0;
            perAddr_ff <= 14'h0;
            perWrite_ff <= 1'b0;
            perProt_ff <= 4'h0;
            perByteEn_ff <= 4'h0;
            perWdata_ff <= 32'h0;
            pendData_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            hrdata_ff <= nxt_hrdata;
            hreadyout_ff <= nxt_hreadyout;
            hresp_ff <= nxt_hresp;
            onEn_ff <= nxt_onEn;
            offEn_ff <= nxt_offEn;
            perAddr_ff <= nxt_perAddr;
            perWrite_ff <= nxt_perWrite;
            perProt_ff <= nxt_perProt;
            perByteEn_ff <= nxt_perByteEn;
            perWdata_ff <= nxt_perWdata;
            pendData_ff <= nxt_pendData;
        end
    end

    // Enables must be one-hot across both ports, lanes nonzero while enabled
    // The check is structural: it looks only at the registered outputs, so
    // it catches a corrupted enable or lane register but not a wrong slot
    // that is still one-hot. On a fault the shadow copy is inverted so the
    // comparator trips on the very next edge.
    assign mainVec = {onEn_ff, offEn_ff};
    assign chkErr = ((|onEn_ff) & (|offEn_ff)) |
                    ((onEn_ff & (onEn_ff - 16'h1)) != 16'h0) |
                    ((offEn_ff & (offEn_ff - 16'h1)) != 16'h0) |
                    ((|mainVec) & (perByteEn_ff == 4'h0));
    assign shadowVec = chkErr ? ~mainVec : mainVec;

    apb_integrity_chk uChk (
        .clk(clk),
        .rst(rst),
        .mainVec(mainVec),
        .shadowVec(shadowVec),
        .mismatch_ff(integrityErr_ff)
    );

    // This instance owns only the slots its address map gives it
    // a sibling instance, selected by its own hsel since no logic here reads APB_INST_ID, covers the rest.
    // Both are built from this module; the split lives in the system map,
    // so no slot is ever decoded by two bridges at once.
endmodule

/* tb/apb_bridge_properties.sv */
// Port-level checks for the bridge
`timescale 1ns/10ps
module apb_bridge_properties (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer
    input wire logic hwrite, // Write
    input wire logic [3:0] hprot, // Attributes
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Ready in
    input wire logic [31:0] protAllow, // User allow
    input wire logic [31:0] protWrAllow, // Write allow
    input wire logic onReady, // On done
    input wire logic hreadyout_ff, // Ready out
    input wire logic hresp_ff, // Error
    input wire logic [15:0] onEn_ff, // On enables
    input wire logic [15:0] offEn_ff, // Off enables
    input wire logic [13:0] perAddr_ff, // Offset
    input wire logic [31:0] perWdata_ff // Data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Accepted request, and whether it lies in the peripheral sub-range
    wire take = hsel && hready && htrans[1];
    wire inWin = haddr[31:19] == 13'h0;
    wire priv = take && inWin && hprot[1];
    // Privileged access that the write grant lets through to a peripheral
    wire fwd = priv && (!hwrite || protWrAllow[haddr[18:14]]);
    // Error answer takes two cycles, the second one ready
    sequence errSeq;
        hresp_ff && !hreadyout_ff ##1 hresp_ff && hreadyout_ff;
    endsequence
    a_one_hot: assert property ($onehot0({onEn_ff, offEn_ff}))
        else $error("more than one enable");
    a_reserved_err: assert property (take && !inWin |=> errSeq)
        else $error("reserved access not refused");
    a_denied_err: assert property (take && inWin && !hprot[1]
        && !protAllow[haddr[18:14]] |=> errSeq)
        else $error("denied access not refused");
    a_err_no_en: assert property (
        hresp_ff |-> !(|{onEn_ff, offEn_ff}))
        else $error("enable during error");
    a_slot_enable: assert property (priv && !hwrite
        |=> {offEn_ff, onEn_ff} == 32'h1 << $past(haddr[18:14]))
        else $error("wrong enable for slot");
    a_offset_fwd: assert property (fwd
        |=> perAddr_ff == $past(haddr[13:0]))
        else $error("wrong offset");
    a_wdata_fwd: assert property (priv && hwrite
        && protWrAllow[haddr[18:14]] |=> ##1 perWdata_ff == $past(hwdata))
        else $error("wrong write data");
    a_hold_en: assert property (|onEn_ff && !onReady
        |=> $stable(onEn_ff) && !hreadyout_ff)
        else $error("enable dropped early");
    a_ready_done: assert property (|onEn_ff && onReady
        |=> !(|onEn_ff) && hreadyout_ff)
        else $error("no completion");
endmodule

/* tb/apb_periph_model.sv */
// Peripheral responder for one bridge port
`timescale 1ns/10ps
module apb_periph_model (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic [15:0] en, // Enables
    input wire logic [13:0] addr, // Offset
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] be, // Byte enables
    input wire logic wr, // Write
    input wire logic [1:0] lat, // Wait cycles
    output logic ready, // Done
    output logic [31:0] rdata, // Read data
    output logic [50:0] seen // Last transfer
);
    logic [1:0] cnt;
    // Data names the enable and offset; inverted while not ready so stale data never matches
    assign rdata = ready ? {en, 2'h0, addr} : ~{en, 2'h0, addr};
    // One-cycle done after lat cycles, slow or prompt
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ready <= 1'b0;
            cnt <= 2'h0;
            seen <= 51'h0;
        end else if (|en && !ready) begin
            ready <= cnt >= lat;
            cnt <= cnt + 2'h1;
        end else begin
            if (ready) seen <= {wr, be, addr, wdata};
            ready <= 1'b0;
            cnt <= 2'h0;
        end
    end
endmodule

/* tb/apb_bridge_test.sv */
// Random and corner transfers through the bridge
`timescale 1ns/10ps
module apb_bridge_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, pa = 32'h0, pw = 32'h0;
    logic [31:0] r, q, hrdata, onRd, offRd;
    logic [1:0] htrans = 2'h0, lat = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [3:0] hprot = 4'h0, pProt, pBe;
    logic hro, hresp, onRdy, offRdy, ierr, pWr;
    logic [15:0] onEn, offEn;
    logic [13:0] pAddr;
    logic [31:0] pWd;
    logic [50:0] onSeen, offSeen;
    int failures = 0, checkCount = 0, seed = 65, k;
    always #2 clk = ~clk;
    apb_bridge i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot),
        .hwdata(hwdata), .hready(hro), .protAllow(pa), .protWrAllow(pw),
        .onRdata(onRd), .onReady(onRdy), .offRdata(offRd),
        .offReady(offRdy), .hrdata_ff(hrdata), .hreadyout_ff(hro),
        .hresp_ff(hresp), .onEn_ff(onEn), .offEn_ff(offEn),
        .perAddr_ff(pAddr), .perWrite_ff(pWr), .perProt_ff(pProt),
        .perByteEn_ff(pBe), .perWdata_ff(pWd), .integrityErr_ff(ierr));
    apb_periph_model i_on (.clk(clk), .rst(rst), .en(onEn), .addr(pAddr),
        .wdata(pWd), .be(pBe), .wr(pWr), .lat(lat), .ready(onRdy),
        .rdata(onRd), .seen(onSeen));
    apb_periph_model i_off (.clk(clk), .rst(rst), .en(offEn), .addr(pAddr),
        .wdata(pWd), .be(pBe), .wr(pWr), .lat(lat), .ready(offRdy),
        .rdata(offRd), .seen(offSeen));
    task automatic cmp(input string n, input logic [50:0] e, s);
        checkCount++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop;
        if (failures == 0 && checkCount > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Lanes from size and low address bits
    function automatic logic [3:0] be_of(input logic [2:0] s, logic [1:0] a);
        if (s == 3'h0) return 4'h1 << a;
        return s == 3'h1 ? (a[1] ? 4'hc : 4'h3) : 4'hf;
    endfunction
    // One transfer; the bridge's own ready paces it, bounded wait
    task automatic xfer(input logic [31:0] a, logic w, logic [2:0] s,
                        logic [3:0] p);
        logic ok;
        logic [31:0] en;
        logic [50:0] sn;
        int i;
        a[1:0] = s == 3'h2 ? 2'h0 : (s == 3'h1 ? {a[1], 1'b0} : a[1:0]);
        ok = a[31:19] == 13'h0 && (p[1] || pa[a[18:14]]);
        ok = ok && (!w || pw[a[18:14]]);
        en = 32'h0;
        @(posedge clk);
        // Select with a non-sequential transfer type
        #1 {hsel, htrans, haddr, hwrite, hsize, hprot} = {3'h6, a, w, s, p};
        hwdata = $random(seed);
        @(posedge clk);
        #1 {hsel, htrans} = 3'h0;
        for (i = 0; i < 40 && !hro; i++) begin
            en = en | {offEn, onEn};
            @(posedge clk);
            #1;
        end
        if (i == 40) begin
            failures++;
            report_and_stop();
        end
        cmp("resp", !ok, hresp);
        cmp("enable", {31'h0, ok} << a[18:14], en);
        if (!ok) return;
        sn = a[18] ? offSeen : onSeen;
        cmp("lanes", {w, be_of(s, a[1:0]), a[13:0]}, sn[50:32]);
        cmp("attr", p, pProt);
        if (w) cmp("wdata", hwdata, sn[31:0]);
        else cmp("rdata", {16'h1 << a[17:14], 2'h0, a[13:0]}, hrdata);
    endtask
    // Corners: sub-range ends, on/off boundary, reserved, outside window
    logic [31:0] corner [6] = '{32'h00000004, 32'h0007c002, 32'h0003c001,
        32'h00040000, 32'h00080000, 32'h04000000};
    initial begin
        repeat (2) @(posedge clk);
        #1 cmp("reset", {1'b1, 32'h0}, {hro, onEn, offEn});
        rst = 1'b0;
        pw = 32'hffffffff;
        for (k = 0; k < 6; k++) xfer(corner[k], k[0], 3'(k % 3), 4'h2);
        // Mid-run reset between transfers must leave the bridge idle
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 cmp("reset again", {1'b1, 32'h0}, {hro, onEn, offEn});
        rst = 1'b0;
        repeat (300) begin
            r = $random(seed);
            q = $random(seed);
            {pa, pw, lat} = {$random(seed), $random(seed), r[6:5]};
            xfer({r[4:2] == 3'h0 ? q[31:19] : 13'h0, q[18:0]}, r[7],
                 r[0] ? 3'h2 : {2'h0, r[1]}, r[11:8]);
        end
        cmp("integrity", 51'h0, ierr);
        report_and_stop();
    end
endmodule
bind apb_bridge apb_bridge_properties i_props (.clk(clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hprot(hprot), .hwdata(hwdata), .hready(hready), .protAllow(protAllow),
    .protWrAllow(protWrAllow), .onReady(onReady),
    .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .onEn_ff(onEn_ff),
    .offEn_ff(offEn_ff), .perAddr_ff(perAddr_ff),
    .perWdata_ff(perWdata_ff));
